// ==== core/card_host.sv ====
// host controller driving the flash card socket pins
`default_nettype none
module card_host
  import card_host_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  // user side
  input wire logic req_valid,
  input wire card_host_pkg::req_t req,
  input wire logic program_enable,
  output logic req_ready,
  output logic rsp_valid,
  output logic [card_host_pkg::DATA_W-1:0] rsp_data,
  output var card_host_pkg::err_t rsp_err,
  output logic card_present,
  output logic write_locked,
  output logic battery_ok,
  // card pins
  output logic [card_host_pkg::ADDR_W-1:0] card_addr,
  output var card_host_pkg::ctrl_t card_ctrl,
  output logic [card_host_pkg::DATA_W-1:0] data_out,
  output logic [card_host_pkg::DATA_W-1:0] data_oe,
  input wire logic [card_host_pkg::DATA_W-1:0] data_in,
  input wire logic insertion_sense_a,
  input wire logic insertion_sense_b,
  input wire logic write_lock_flag,
  input wire logic battery_sense_one,
  input wire logic battery_sense_two
);
  import card_host_pkg::*;

  // refuse access, pulse and hold plus recover counts the sequencer counter cannot hold
  if (N_ACCESS < 1 || N_PULSE < 1 || N_SETUP < 1 || ADDR_W < 2 || N_ACCESS + 3 > 255
      || N_PULSE > 255 || N_HOLD + N_RECOVER > 255) begin : g_bad_cfg
    $error("card_host: timing or width unusable");
  end

  // ----------------------------------------------------------------
  // status and data pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] stat;
  pin_sync #(.W(4)) u_stat (
    .mclk(mclk),
    .rst(rst),
    .din({insertion_sense_a, insertion_sense_b, write_lock_flag, battery_sense_one & battery_sense_two}),
    .dout(stat)
  );
  logic [DATA_W-1:0] rd_sync;
  pin_sync #(.W(DATA_W)) u_data (
    .mclk(mclk),
    .rst(rst),
    .din(data_in),
    .dout(rd_sync)
  );
  logic inserted;
  assign inserted = ~stat[3] & ~stat[2];

  // ----------------------------------------------------------------
  // bus cycle sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_READ, S_SETTLE, S_DONE} state_t;
  localparam int CW = 8;
  localparam logic [CW-1:0] C_SETUP = CW'(N_SETUP);
  localparam logic [CW-1:0] C_PULSE = CW'(N_PULSE);
  localparam logic [CW-1:0] C_HOLD = CW'(N_HOLD + N_RECOVER);
  localparam logic [CW-1:0] C_READ = CW'(N_ACCESS + 3);

  state_t state, next_state;
  logic [CW-1:0] cnt, next_cnt;
  req_t cur, next_cur;
  ctrl_t next_ctrl;
  logic [ADDR_W-1:0] next_addr;
  logic [DATA_W-1:0] next_dout, next_doe, next_rsp_data;
  logic next_rsp_valid, next_ready;
  err_t next_err;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_cur = cur;
    next_ctrl = card_ctrl;
    next_addr = card_addr;
    next_dout = data_out;
    next_doe = data_oe;
    next_rsp_data = rsp_data;
    next_rsp_valid = 1'b0;
    next_err = rsp_err;
    next_ready = 1'b0;
    // program supply follows user enable for both lanes
    next_ctrl.low_byte_program_supply = program_enable;
    next_ctrl.high_byte_program_supply = program_enable;
    next_ctrl.attribute_space_select_n = 1'b1;
    case (state)
      S_IDLE: begin
        // one transfer at a time, so never overlapping bus cycles
        next_ready = 1'b1;
        if (req_valid && req_ready) begin
          next_ready = 1'b0;
          next_cur = req;
          next_cnt = '0;
          if (!inserted) begin
            next_err = ERR_NO_CARD;
            next_state = S_DONE;
          end else if (req.write && stat[1]) begin
            next_err = ERR_LOCKED;
            next_state = S_DONE;
          end else if (req.write && !program_enable) begin
            next_err = ERR_NO_VPP;
            next_state = S_DONE;
          end else begin
            next_err = ERR_NONE;
            next_addr = req.addr;
            // word mode: both selects; byte mode: low select only
            next_ctrl.low_byte_card_select_n = 1'b0;
            next_ctrl.high_byte_card_select_n = ~req.word_mode;
            if (req.write) begin
              next_dout = req.word_mode ? req.wdata : {8'h00, req.wdata[7:0]};
              next_doe = req.word_mode ? 16'hFFFF : 16'h00FF;
              next_state = S_SETUP;
            end else begin
              next_ctrl.output_gate_n = 1'b0;
              next_state = S_READ;
            end
          end
        end
      end
      S_SETUP: begin
        next_cnt = cnt + 1'b1;
        if (cnt + 1'b1 >= C_SETUP) begin
          next_cnt = '0;
          next_ctrl.write_strobe_n = 1'b0;
          next_state = S_STROBE;
        end
      end
      S_STROBE: begin
        next_cnt = cnt + 1'b1;
        if (cnt + 1'b1 >= C_PULSE) begin
          next_cnt = '0;
          next_ctrl.write_strobe_n = 1'b1;
          next_state = S_HOLD;
        end
      end
      S_HOLD: begin
        next_cnt = cnt + 1'b1;
        if (cnt + 1'b1 >= C_HOLD) begin
          next_doe = '0;
          next_ctrl.low_byte_card_select_n = 1'b1;
          next_ctrl.high_byte_card_select_n = 1'b1;
          next_state = S_DONE;
        end
      end
      S_READ: begin
        next_cnt = cnt + 1'b1;
        if (cnt + 1'b1 >= C_READ) begin
          next_rsp_data = cur.word_mode ? rd_sync : {8'h00, rd_sync[7:0]};
          next_ctrl.output_gate_n = 1'b1;
          next_ctrl.low_byte_card_select_n = 1'b1;
          next_ctrl.high_byte_card_select_n = 1'b1;
          next_cnt = '0;
          next_state = S_SETTLE;
        end
      end
      S_SETTLE: begin
        next_cnt = cnt + 1'b1;
        if (cnt + 1'b1 >= C_HOLD) begin
          next_state = S_DONE;
        end
      end
      S_DONE: begin
        next_rsp_valid = 1'b1;
        next_state = S_IDLE;
        next_ready = 1'b1;
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= S_IDLE;
      cnt <= '0;
      cur <= '0;
      card_ctrl <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
      card_addr <= '0;
      data_out <= '0;
      data_oe <= '0;
      rsp_data <= '0;
      rsp_valid <= 1'b0;
      rsp_err <= ERR_NONE;
      req_ready <= 1'b0;
      card_present <= 1'b0;
      write_locked <= 1'b0;
      battery_ok <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      cur <= next_cur;
      card_ctrl <= next_ctrl;
      card_addr <= next_addr;
      data_out <= next_dout;
      data_oe <= next_doe;
      rsp_data <= next_rsp_data;
      rsp_valid <= next_rsp_valid;
      rsp_err <= next_err;
      req_ready <= next_ready;
      card_present <= inserted;
      write_locked <= stat[1];
      battery_ok <= stat[0];
    end
  end
endmodule : card_host
`default_nettype wire

// ==== core/card_host_pkg.sv ====
// constants and carrier types for the flash card host controller
`default_nettype none
package card_host_pkg;
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam int CLK_MHZ = 50;
  // bus cycle times in ns
  localparam int T_CYCLE_NS = 200;
  localparam int T_WE_PULSE_NS = 120;
  localparam int T_ADDR_SETUP_NS = 20;
  localparam int T_DATA_HOLD_NS = 30;
  localparam int T_OE_ACCESS_NS = 200;
  localparam int T_WRITE_RECOVER_NS = 30;
  localparam int N_SETUP = (T_ADDR_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int N_PULSE = (T_WE_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int N_HOLD = (T_DATA_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int N_ACCESS = (T_OE_ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam int N_RECOVER = (T_WRITE_RECOVER_NS * CLK_MHZ + 999) / 1000;
  localparam logic [ADDR_W-1:0] CARD_INFO_BASE = 22'h000000;
  typedef struct packed {
    logic write;
    logic word_mode;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } req_t;
  typedef struct packed {
    logic low_byte_card_select_n;
    logic high_byte_card_select_n;
    logic output_gate_n;
    logic write_strobe_n;
    logic low_byte_program_supply;
    logic high_byte_program_supply;
    logic attribute_space_select_n;
  } ctrl_t;
  typedef enum logic [1:0] {ERR_NONE, ERR_NO_CARD, ERR_LOCKED, ERR_NO_VPP} err_t;
endpackage : card_host_pkg
`default_nettype wire

// ==== core/pin_sync.sv ====
// three-stage synchroniser, change accepted when last two stages agree
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1, s2, s3;
  logic [W-1:0] next_dout;
  always_comb begin
    next_dout = dout;
    for (int i = 0; i < W; i++) begin
      if (s2[i] == s3[i]) begin
        next_dout[i] = s3[i];
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      dout <= '0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      dout <= next_dout;
    end
  end
endmodule : pin_sync
`default_nettype wire

// ==== dv/card_host_asserts.sv ====
// concurrent checks on the card host pins
`default_nettype none
module card_host_asserts
  import card_host_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic req_valid,
  input wire card_host_pkg::req_t req,
  input wire logic program_enable,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire card_host_pkg::err_t rsp_err,
  input wire logic card_present,
  input wire logic write_locked,
  input wire card_host_pkg::ctrl_t card_ctrl,
  input wire logic [card_host_pkg::DATA_W-1:0] data_oe,
  input wire logic insertion_sense_a
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  strobe_sel_a: assert property (!card_ctrl.write_strobe_n |-> !card_ctrl.low_byte_card_select_n)
    else $error("strobe low without select");
  strobe_vpp_a: assert property (!card_ctrl.write_strobe_n |-> card_ctrl.low_byte_program_supply)
    else $error("strobe low without program supply");
  gate_strobe_a: assert property (!(!card_ctrl.output_gate_n && !card_ctrl.write_strobe_n))
    else $error("gate and strobe low together");
  oe_gate_a: assert property ((data_oe != '0) |-> card_ctrl.output_gate_n)
    else $error("host drives data during read");
  pulse_len_a: assert property ($fell(card_ctrl.write_strobe_n) |-> !card_ctrl.write_strobe_n [*6])
    else $error("strobe pulse too short");
  attr_off_a: assert property (card_ctrl.attribute_space_select_n)
    else $error("attribute select driven low");
  sense_gone_a: assert property (insertion_sense_a [*8] |-> !card_present)
    else $error("card present with sense high");
  lock_err_a: assert property ((req_valid && req_ready && req.write && write_locked && card_present
    && program_enable) |-> card_ctrl.write_strobe_n throughout ##[1:3] (rsp_valid && rsp_err == ERR_LOCKED))
    else $error("locked write not refused");
endmodule : card_host_asserts
bind card_host card_host_asserts card_host_asserts_inst (.mclk(mclk), .rst(rst), .req_valid(req_valid),
  .req(req), .program_enable(program_enable), .req_ready(req_ready), .rsp_valid(rsp_valid),
  .rsp_err(rsp_err), .card_present(card_present), .write_locked(write_locked), .card_ctrl(card_ctrl),
  .data_oe(data_oe), .insertion_sense_a(insertion_sense_a));
`default_nettype wire

// ==== dv/card_model.sv ====
// behavioural flash card seen from its socket pins
`default_nettype none
module card_model
  import card_host_pkg::*;
(
  input wire logic [card_host_pkg::ADDR_W-1:0] card_addr,
  input wire card_host_pkg::ctrl_t card_ctrl,
  input wire logic [card_host_pkg::DATA_W-1:0] bus,
  input wire logic present,
  input wire logic lock_sw,
  output logic [card_host_pkg::DATA_W-1:0] card_q,
  output logic insertion_sense_a,
  output logic insertion_sense_b,
  output logic write_lock_flag,
  output logic battery_sense_one,
  output logic battery_sense_two
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [int];
  logic [ADDR_W-1:0] la;
  logic [15:0] last = 16'h0000;
  logic [15:0] w;
  logic [15:0] rw;
  logic lo_n, hi_n, en;
  assign lo_n = card_ctrl.low_byte_card_select_n;
  assign hi_n = card_ctrl.high_byte_card_select_n;
  assign insertion_sense_a = !present;
  assign insertion_sense_b = !present;
  assign write_lock_flag = lock_sw;
  assign battery_sense_one = 1'b1;
  assign battery_sense_two = 1'b1;
  assign en = present && !card_ctrl.output_gate_n && !(lo_n && hi_n);
  always @(negedge card_ctrl.write_strobe_n) la = card_addr;
  always @(posedge card_ctrl.write_strobe_n) begin
    w = mem.exists(la >> 1) ? mem[la >> 1] : 16'hFFFF;
    // low byte supply low or lock on leaves contents alone
    if (!lock_sw && !lo_n && card_ctrl.low_byte_program_supply) begin
      if (!hi_n && card_ctrl.high_byte_program_supply) w = bus;
      else if (la[0]) w[15:8] = bus[7:0];
      else w[7:0] = bus[7:0];
      // flat array; zone command state, erase and verify not modelled
      mem[la >> 1] = w;
    end
  end
  always @* begin
    rw = mem.exists(card_addr >> 1) ? mem[card_addr >> 1] : 16'hFFFF;
    if (en) begin
      card_q = (hi_n && card_addr[0]) ? {8'h00, rw[15:8]} : rw;
      last = card_q;
    end else card_q = ~last;
  end
endmodule : card_model
`default_nettype wire

// ==== dv/tb.sv ====
// testbench for the card host controller
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import card_host_pkg::*;
  logic mclk = 0, rst = 1, req_valid = 0, program_enable = 0, present = 1, lock_sw = 0;
  req_t req = '0;
  logic req_ready, rsp_valid, card_present, write_locked, battery_ok;
  logic isa, isb, wlf, bs1, bs2;
  logic [DATA_W-1:0] rsp_data, data_out, data_oe, card_q, bus, rd;
  logic [ADDR_W-1:0] card_addr;
  ctrl_t card_ctrl;
  err_t rsp_err, er;
  int errors = 0, n_checks = 0, cyc = 0;
  always #10 mclk = ~mclk;
  assign bus = (data_oe & data_out) | (~data_oe & card_q);
  card_host card_host_inst (.mclk(mclk), .rst(rst), .req_valid(req_valid), .req(req),
    .program_enable(program_enable), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_err(rsp_err), .card_present(card_present), .write_locked(write_locked), .battery_ok(battery_ok),
    .card_addr(card_addr), .card_ctrl(card_ctrl), .data_out(data_out), .data_oe(data_oe), .data_in(bus),
    .insertion_sense_a(isa), .insertion_sense_b(isb), .write_lock_flag(wlf),
    .battery_sense_one(bs1), .battery_sense_two(bs2));
  card_model card_model_inst (.card_addr(card_addr), .card_ctrl(card_ctrl), .bus(bus), .present(present),
    .lock_sw(lock_sw), .card_q(card_q), .insertion_sense_a(isa), .insertion_sense_b(isb),
    .write_lock_flag(wlf), .battery_sense_one(bs1), .battery_sense_two(bs2));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic do_req(input logic wr, input logic wm, input logic [ADDR_W-1:0] a, input logic [15:0] d);
    int k;
    k = 0;
    while (req_ready !== 1'b1 && k < 50) begin
      @(negedge mclk);
      k++;
    end
    req = '{write: wr, word_mode: wm, addr: a, wdata: d};
    req_valid = 1;
    @(negedge mclk);
    req_valid = 0;
    k = 0;
    while (rsp_valid !== 1'b1 && k < 60) begin
      @(negedge mclk);
      k++;
    end
    chk({15'h0000, rsp_valid}, 16'h0001);
    rd = rsp_data;
    er = rsp_err;
  endtask : do_req
  task automatic t_status;
    chk({14'h0000, card_present, battery_ok}, 16'h0003);
    $display("status test done");
  endtask : t_status
  task automatic t_write_read;
    program_enable = 1;
    do_req(1, 1, 22'h000000, 16'hA5C3);
    chk({14'h0000, er}, {14'h0000, ERR_NONE});
    do_req(0, 1, 22'h000000, 16'h0000);
    chk(rd, 16'hA5C3);
    do_req(0, 0, 22'h000001, 16'h0000);
    chk(rd, 16'h00A5);
    do_req(1, 0, 22'h000001, 16'h005A);
    chk({14'h0000, er}, {14'h0000, ERR_NONE});
    do_req(0, 1, 22'h000000, 16'h0000);
    chk(rd, 16'h5AC3);
    do_req(1, 1, 22'h000000, 16'hA5C3);
    $display("write read test done");
  endtask : t_write_read
  task automatic t_no_vpp;
    program_enable = 0;
    repeat (3) @(negedge mclk);
    do_req(1, 1, 22'h000000, 16'h1234);
    chk({14'h0000, er}, {14'h0000, ERR_NO_VPP});
    do_req(0, 1, 22'h000000, 16'h0000);
    chk(rd, 16'hA5C3);
    $display("no supply test done");
  endtask : t_no_vpp
  task automatic t_lock;
    program_enable = 1;
    lock_sw = 1;
    repeat (8) @(negedge mclk);
    chk({15'h0000, write_locked}, 16'h0001);
    do_req(1, 1, 22'h000000, 16'h5A5A);
    chk({14'h0000, er}, {14'h0000, ERR_LOCKED});
    lock_sw = 0;
    $display("lock test done");
  endtask : t_lock
  task automatic t_absent;
    present = 0;
    repeat (10) @(negedge mclk);
    chk({15'h0000, card_present}, 16'h0000);
    do_req(0, 1, 22'h000000, 16'h0000);
    chk({14'h0000, er}, {14'h0000, ERR_NO_CARD});
    $display("absent test done");
  endtask : t_absent
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      test_done();
    end
  end
  initial begin
    repeat (8) @(negedge mclk);
    rst = 0;
    repeat (10) @(negedge mclk);
    t_status();
    t_write_read();
    t_no_vpp();
    t_lock();
    t_absent();
    test_done();
  end
endmodule : tb
`default_nettype wire
